/* File: core/flash_status_pkg.sv */
// Function
// R1: any of four main-array regions can become OTP; then program/erase is refused
// R2: regions are the parameter group plus three adjacent main blocks, top or bottom
// R3: host drives upper address lines high when programming OTP bits on top parts
// R4: async page non-array reads: only the first word is guaranteed
// R5: sync burst non-array reads repeat the same word until burst length is met
// R6: read-status command is accepted at any address, then reads return status
// R7: after program, erase or lock sequences, reads return status until next command
// R8: status reads drive status on the low byte and zero on the high byte
// R9: async mode latches a fresh status snapshot on the earlier of OE or CE falling
// R10: host toggles CE or address valid to refresh status in sync burst mode
// R11: bit 7 is 0 while busy, 1 when ready
// R12: bit 6 is 1 while erase suspend is in effect
// R13: bit 5 sets on erase failure; with bits 4 and 7 means sequence error
// R14: bit 4 sets on program failure; with bits 5 and 7 means sequence error
// R15: bit 3 sets when the program supply drops below lockout during an operation
// R16: bit 2 is 1 while program suspend is in effect
// R17: bit 1 sets when program or erase targets a locked block; operation aborts
// R18: bit 0 is 1 while buffered factory programming runs, 0 once done
// R19: reset returns status to the ready-only default
// R20: clear-status clears the word whatever the supply level
// R21: bits 7, 6, 2 follow the engine; bits 5, 4, 3, 1 are sticky
// R22: a sequence error in erase suspend stays set through resume
// R23: erase-resume at any address restarts erase and clears bits 7 and 6
package flash_status_pkg;

  localparam logic [7:0] STAT_RESET = 8'h80;
  localparam logic [7:0] STAT_UPPER = 8'h00;
  localparam logic [20:0] PIN_IDLE = 21'h1F0000;

  localparam int STAT_READY = 7;
  localparam int STAT_ESUSP = 6;
  localparam int STAT_EFAIL = 5;
  localparam int STAT_PFAIL = 4;
  localparam int STAT_VPP = 3;
  localparam int STAT_PSUSP = 2;
  localparam int STAT_LOCKED = 1;
  localparam int STAT_FACTORY = 0;

  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_CFI = 8'h98;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_WORD_PROG = 8'h40;
  localparam logic [7:0] CMD_WORD_PROG_ALT = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK = 8'h01;
  localparam logic [7:0] CMD_LOCKDOWN = 8'h2F;
  localparam logic [7:0] CMD_CFG_READ = 8'h03;

  localparam int PARAM_GROUP = 4;
  localparam int OTP_SPAN = 7;
  localparam int NUM_BLOCKS_DEF = 259;
  localparam int BLOCK_W_DEF = 9;

  localparam logic [2:0] BL_4 = 3'h1;
  localparam logic [2:0] BL_8 = 3'h2;
  localparam logic [2:0] BL_16 = 3'h3;
  localparam logic [4:0] LEN_4 = 5'h04;
  localparam logic [4:0] LEN_8 = 5'h08;
  localparam logic [4:0] LEN_16 = 5'h10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_PROG = 2'h1,
    ST_ERASE = 2'h3,
    ST_LOCK = 2'h2
  } cmd_state_t;

endpackage

/* File: core/flash_status_core.sv */
`timescale 1ns/100ps
module flash_status_core
  import flash_status_pkg::*;
#(
  parameter int NUM_BLOCKS = NUM_BLOCKS_DEF,
  parameter int BLOCK_W = BLOCK_W_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // parallel bus pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic address_valid_n,
  input wire logic burst_clk,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe,
  // read configuration
  input wire logic sync_mode,
  input wire logic [2:0] burst_len,
  // array read data
  input wire logic [15:0] array_data,
  // write state machine side
  input wire logic engine_busy,
  input wire logic engine_erase_suspended,
  input wire logic engine_program_suspended,
  input wire logic factory_busy,
  input wire logic erase_fail_evt,
  input wire logic program_fail_evt,
  input wire logic locked_block_evt,
  input wire logic supply_low,
  output logic op_program,
  output logic op_erase,
  output logic op_suspend,
  output logic op_resume,
  // selectable otp regions
  input wire logic top_param,
  input wire logic [3:0] otp_region_en,
  input wire logic [BLOCK_W-1:0] target_block,
  output logic otp_refused,
  // status view
  output logic [7:0] write_state_status,
  output logic status_mode,
  output logic burst_done
);

  if (NUM_BLOCKS < OTP_SPAN || NUM_BLOCKS > (1 << BLOCK_W)) begin : g_bad_cfg
    $error("NUM_BLOCKS does not fit BLOCK_W or is too small");
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [20:0] sync1_q;
  logic [20:0] sync2_q;
  logic [4:0] prev_q;
  logic ce_s;
  logic oe_s;
  logic we_s;
  logic adv_s;
  logic bclk_s;
  logic [7:0] cmd;

  assign ce_s = sync2_q[20];
  assign oe_s = sync2_q[19];
  assign we_s = sync2_q[18];
  assign adv_s = sync2_q[17];
  assign bclk_s = sync2_q[16];
  assign cmd = sync2_q[7:0];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_q <= PIN_IDLE;
      sync2_q <= PIN_IDLE;
      prev_q <= PIN_IDLE[20:16];
    end else begin
      sync1_q <= {ce_n, oe_n, we_n, address_valid_n, burst_clk, dq_in};
      sync2_q <= sync1_q;
      prev_q <= sync2_q[20:16];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // command decode

  function automatic logic [2:0] otp_region(input logic [BLOCK_W-1:0] blk, input logic top);
    logic [BLOCK_W-1:0] base;
    logic [BLOCK_W-1:0] off;
    base = top ? BLOCK_W'(NUM_BLOCKS - OTP_SPAN) : '0;
    off = blk - base;
    if (blk < base || off >= BLOCK_W'(OTP_SPAN)) begin
      otp_region = 3'h0;
    end else if (top) begin
      otp_region = (off >= BLOCK_W'(OTP_SPAN - PARAM_GROUP)) ? 3'h4 :
        {1'b1, 2'(OTP_SPAN - PARAM_GROUP - int'(off))};
    end else begin
      otp_region = (off < BLOCK_W'(PARAM_GROUP)) ? 3'h4 : {1'b1, 2'(int'(off) - PARAM_GROUP + 1)};
    end
  endfunction

  cmd_state_t state_q;
  cmd_state_t state_d;
  logic [7:0] stat_q;
  logic [7:0] stat_d;
  logic status_mode_q;
  logic hold_q;
  logic resume_q;
  logic cmd_stb;
  logic idle_cmd;
  logic prog_go;
  logic erase_go;
  logic lock_cmd_ok;
  logic lock_ok;
  logic seq_err;
  logic clr_cmd;
  logic resume_cmd;
  logic suspend_cmd;
  logic status_cmd;
  logic leave_cmd;
  logic start_req;
  logic [2:0] region;
  logic otp_hit;
  logic refused;
  logic start_any;

  // a write ends on the rising edge of write enable while selected
  assign cmd_stb = we_s & ~prev_q[2] & ~ce_s;
  assign idle_cmd = cmd_stb & (state_q == ST_IDLE);
  assign prog_go = cmd_stb & (state_q == ST_PROG);
  assign erase_go = cmd_stb & (state_q == ST_ERASE) & (cmd == CMD_CONFIRM);
  assign lock_cmd_ok = (cmd == CMD_LOCK) | (cmd == CMD_CONFIRM) | (cmd == CMD_LOCKDOWN);
  assign lock_ok = cmd_stb & (state_q == ST_LOCK) & lock_cmd_ok;
  assign seq_err = cmd_stb & (((state_q == ST_ERASE) & (cmd != CMD_CONFIRM)) |
    ((state_q == ST_LOCK) & ~lock_cmd_ok & (cmd != CMD_CFG_READ))); // R13 R14
  // address is never decoded for these commands
  assign clr_cmd = idle_cmd & (cmd == CMD_CLEAR_STATUS); // R20
  assign resume_cmd = idle_cmd & (cmd == CMD_CONFIRM) & stat_q[STAT_ESUSP]; // R23
  assign suspend_cmd = idle_cmd & (cmd == CMD_SUSPEND);
  assign status_cmd = idle_cmd & (cmd == CMD_READ_STATUS); // R6
  assign leave_cmd = idle_cmd & ((cmd == CMD_READ_ARRAY) | (cmd == CMD_READ_ID) | (cmd == CMD_READ_CFI));

  assign region = otp_region(target_block, top_param); // R2
  assign otp_hit = region[2] & otp_region_en[region[1:0]];
  assign start_req = prog_go | erase_go;
  assign refused = start_req & otp_hit; // R1
  assign start_any = (start_req & ~otp_hit) | resume_cmd;

  assign state_d = !cmd_stb ? state_q :
    (state_q != ST_IDLE) ? ST_IDLE :
    ((cmd == CMD_WORD_PROG) | (cmd == CMD_WORD_PROG_ALT)) ? ST_PROG :
    (cmd == CMD_ERASE_SETUP) ? ST_ERASE :
    (cmd == CMD_LOCK_SETUP) ? ST_LOCK : ST_IDLE;

  //////////////////////////////////////////////////////////////////////////////
  // status word

  // bit 7 is held low from the start until the engine reports busy,
  // so a read in the gap never shows a stale ready
  assign stat_d[STAT_READY] = ~engine_busy & ~(hold_q | start_any); // R11 R21 R23
  assign stat_d[STAT_ESUSP] = engine_erase_suspended & ~resume_q & ~resume_cmd; // R12 R23
  // sticky bits: set wins over a clear in the same cycle
  assign stat_d[STAT_EFAIL] = (stat_q[STAT_EFAIL] & ~clr_cmd) | erase_fail_evt | seq_err; // R13 R21 R22
  assign stat_d[STAT_PFAIL] = (stat_q[STAT_PFAIL] & ~clr_cmd) | program_fail_evt | seq_err; // R14 R21 R22
  assign stat_d[STAT_VPP] = (stat_q[STAT_VPP] & ~clr_cmd) | (supply_low & engine_busy); // R15 R21
  assign stat_d[STAT_PSUSP] = engine_program_suspended; // R16
  assign stat_d[STAT_LOCKED] = (stat_q[STAT_LOCKED] & ~clr_cmd) | locked_block_evt | refused; // R17 R1
  assign stat_d[STAT_FACTORY] = factory_busy; // R18

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      stat_q <= STAT_RESET; // R19
      status_mode_q <= 1'b0;
      hold_q <= 1'b0;
      resume_q <= 1'b0;
    end else begin
      state_q <= state_d;
      stat_q <= stat_d;
      status_mode_q <= (status_mode_q & ~leave_cmd) | status_cmd | start_req | lock_ok | seq_err | suspend_cmd; // R7
      hold_q <= (hold_q & ~engine_busy) | start_any;
      resume_q <= (resume_q & engine_erase_suspended) | resume_cmd;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      op_program <= 1'b0;
      op_erase <= 1'b0;
      op_suspend <= 1'b0;
      op_resume <= 1'b0;
      otp_refused <= 1'b0;
    end else begin
      op_program <= prog_go & ~otp_hit; // R1 R17
      op_erase <= erase_go & ~otp_hit; // R1 R17
      op_suspend <= suspend_cmd;
      op_resume <= resume_cmd; // R23
      otp_refused <= refused;
    end
  end

  assign write_state_status = stat_q;
  assign status_mode = status_mode_q;

  //////////////////////////////////////////////////////////////////////////////
  // read path

  logic [7:0] snap_q;
  logic [4:0] cnt_q;
  logic [4:0] burst_lim;
  logic [15:0] dq_out_q;
  logic dq_oe_q;
  logic out_stat_q;
  logic rd_act;
  logic ce_fall;
  logic adv_fall;
  logic read_fall;
  logic snap_now;
  logic bclk_rise;

  assign rd_act = ~ce_s & ~oe_s & we_s;
  assign ce_fall = ~ce_s & prev_q[4];
  assign adv_fall = ~adv_s & prev_q[1];
  // earlier of the two enables falling opens the read
  assign read_fall = prev_q[4] & prev_q[3] & ~(ce_s & oe_s); // R9
  // a running burst never refreshes; only a new cycle does
  assign snap_now = sync_mode ? (ce_fall | adv_fall) : read_fall; // R9 R10
  assign bclk_rise = bclk_s & ~prev_q[0];
  // continuous burst gives zero, which never completes
  assign burst_lim = (burst_len == BL_4) ? LEN_4 :
    (burst_len == BL_8) ? LEN_8 :
    (burst_len == BL_16) ? LEN_16 : 5'h00;
  assign burst_done = (burst_lim != 5'h00) & (cnt_q >= burst_lim); // R5

  always_ff @(posedge clk) begin
    if (!rstn) begin
      snap_q <= STAT_RESET;
      cnt_q <= 5'h00;
      dq_out_q <= 16'h0000;
      dq_oe_q <= 1'b0;
      out_stat_q <= 1'b0;
    end else begin
      if (snap_now) begin
        snap_q <= stat_q; // R9
      end
      if (ce_fall | adv_fall) begin
        cnt_q <= 5'h00;
      end else if (sync_mode & rd_act & bclk_rise & ~burst_done) begin
        cnt_q <= cnt_q + 5'h01; // R5
      end
      // page address is ignored for status, so later page words just repeat
      dq_out_q <= status_mode_q ? {STAT_UPPER, snap_q} : array_data; // R8 R4 R5
      dq_oe_q <= rd_act;
      out_stat_q <= status_mode_q;
    end
  end

  assign dq_out = dq_out_q;
  assign dq_oe = dq_oe_q;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_reset_value;
    $rose(rstn) |-> write_state_status == STAT_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("status not at default after reset"); // R19

  property p_upper_zero;
    out_stat_q |-> dq_out[15:8] == STAT_UPPER;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("high byte not zero on status read"); // R8

  property p_busy_low;
    engine_busy |=> !write_state_status[STAT_READY];
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("ready bit set while busy"); // R11

  property p_esusp;
    engine_erase_suspended && !resume_q && !resume_cmd |=> write_state_status[STAT_ESUSP];
  endproperty
  a_esusp: assert property (p_esusp) else $error("erase suspend bit missing"); // R12

  property p_psusp;
    engine_program_suspended |=> write_state_status[STAT_PSUSP];
  endproperty
  a_psusp: assert property (p_psusp) else $error("program suspend bit missing"); // R16

  property p_seq_err;
    seq_err |=> write_state_status[STAT_EFAIL] && write_state_status[STAT_PFAIL];
  endproperty
  a_seq_err: assert property (p_seq_err) else $error("sequence error not flagged"); // R13 R14

  property p_sticky;
    write_state_status[STAT_VPP] && !clr_cmd |=> write_state_status[STAT_VPP];
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky bit dropped without clear"); // R21

  property p_clear;
    clr_cmd && !erase_fail_evt && !seq_err |=> !write_state_status[STAT_EFAIL];
  endproperty
  a_clear: assert property (p_clear) else $error("clear status left error bit"); // R20

  property p_resume;
    resume_cmd |=> !write_state_status[STAT_READY] && !write_state_status[STAT_ESUSP] && op_resume;
  endproperty
  a_resume: assert property (p_resume) else $error("resume did not clear bits 7 and 6"); // R23

  property p_otp_refuse;
    refused |=> write_state_status[STAT_LOCKED] && !op_program && !op_erase && otp_refused;
  endproperty
  a_otp_refuse: assert property (p_otp_refuse) else $error("otp region not refused"); // R1

  property p_auto_status;
    start_req || status_cmd |=> status_mode_q;
  endproperty
  a_auto_status: assert property (p_auto_status) else $error("status output not entered"); // R7

  property p_burst_repeat;
    (sync_mode && status_mode_q && !snap_now)[*2] |=> $stable(dq_out);
  endproperty
  a_burst_repeat: assert property (p_burst_repeat) else $error("status word changed in burst"); // R5

  property p_snap_hold;
    !sync_mode && !snap_now |=> $stable(snap_q);
  endproperty
  a_snap_hold: assert property (p_snap_hold) else $error("async snapshot changed mid read"); // R9

  property p_supply_low;
    supply_low && engine_busy |=> write_state_status[STAT_VPP];
  endproperty
  a_supply_low: assert property (p_supply_low) else $error("low supply during operation not flagged"); // R15

  property p_factory_busy;
    factory_busy |=> write_state_status[STAT_FACTORY];
  endproperty
  a_factory_busy: assert property (p_factory_busy) else $error("factory programming bit missing"); // R18

  c_program: cover property (start_req ##[1:20] engine_busy);
  c_seq_err: cover property (seq_err ##1 clr_cmd);
  c_otp: cover property (refused);
  c_burst: cover property (status_mode_q && burst_done);

endmodule

/* File: test/flash_host_model.sv */
`timescale 1ns/100ps
module flash_host_model (
  // clock
  input wire logic clk,
  // bus pins
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic address_valid_n,
  output logic burst_clk,
  output logic [15:0] dq_in,
  // device answers
  input wire logic [15:0] dq_out,
  input wire logic burst_done
);
  logic [15:0] beats[$];
  logic done_seen;
  initial begin
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    address_valid_n = 1'b1;
    burst_clk = 1'b0;
    dq_in = 16'hFFFF;
    done_seen = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // pins pass two sync flops, so every phase lasts at least three clocks
  task automatic write_cmd(input logic [7:0] c);
    tick(1);
    ce_n = 1'b0;
    we_n = 1'b0;
    dq_in = {8'h00, c};
    tick(3);
    we_n = 1'b1;
    tick(3);
    ce_n = 1'b1;
    // released bus shows no stale command
    dq_in = ~dq_in;
    tick(4);
  endtask
  // burst clock only runs inside a read
  task automatic read_word(input int n);
    beats.delete();
    tick(1);
    ce_n = 1'b0;
    oe_n = 1'b0;
    address_valid_n = 1'b0;
    tick(3);
    address_valid_n = 1'b1;
    tick(2);
    beats.push_back(dq_out);
    repeat (n) begin
      burst_clk = 1'b1;
      tick(3);
      beats.push_back(dq_out);
      burst_clk = 1'b0;
      tick(2);
    end
    done_seen = burst_done;
    ce_n = 1'b1;
    oe_n = 1'b1;
    tick(4);
  endtask
endmodule

/* File: test/flash_status_and_otp_region_logic_tb.sv */
`timescale 1ns/100ps
module flash_status_and_otp_region_logic_tb;
  import flash_status_pkg::*;
  localparam int NB = 67;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce_n, oe_n, we_n, address_valid_n, burst_clk, dq_oe, status_mode, burst_done, otp_refused;
  logic [15:0] dq_in, dq_out;
  logic [15:0] array_data = 16'h0000;
  logic sync_mode = 1'b0;
  logic [2:0] burst_len = BL_4;
  logic engine_busy = 1'b0, engine_erase_suspended = 1'b0, engine_program_suspended = 1'b0, factory_busy = 1'b0;
  logic erase_fail_evt = 1'b0, program_fail_evt = 1'b0, locked_block_evt = 1'b0, supply_low = 1'b0;
  logic op_program, op_erase, op_suspend, op_resume;
  logic top_param = 1'b0;
  logic [3:0] otp_region_en = 4'h0;
  logic [6:0] target_block = 7'h00;
  logic [7:0] write_state_status;
  int num_errors = 0, cmp_count = 0, cycles = 0, seed = 30, n_prog = 0, n_oth = 0, n_ref = 0, n_oe = 0, oe0 = 0;

  always #20 clk = ~clk;

  flash_host_model i_flash_host_model (.clk(clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .address_valid_n(address_valid_n), .burst_clk(burst_clk), .dq_in(dq_in), .dq_out(dq_out),
    .burst_done(burst_done));

  flash_status_core #(.NUM_BLOCKS(NB), .BLOCK_W(7)) i_flash_status_core (.clk(clk), .rstn(rstn),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .address_valid_n(address_valid_n), .burst_clk(burst_clk),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .sync_mode(sync_mode), .burst_len(burst_len),
    .array_data(array_data), .engine_busy(engine_busy), .engine_erase_suspended(engine_erase_suspended),
    .engine_program_suspended(engine_program_suspended), .factory_busy(factory_busy),
    .erase_fail_evt(erase_fail_evt),
    .program_fail_evt(program_fail_evt), .locked_block_evt(locked_block_evt), .supply_low(supply_low),
    .op_program(op_program), .op_erase(op_erase), .op_suspend(op_suspend), .op_resume(op_resume),
    .top_param(top_param), .otp_region_en(otp_region_en), .target_block(target_block),
    .otp_refused(otp_refused), .write_state_status(write_state_status), .status_mode(status_mode),
    .burst_done(burst_done));

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if ((op_program | op_erase) === 1'b1) n_prog <= n_prog + 1;
    if ((op_suspend | op_resume) === 1'b1) n_oth <= n_oth + 1;
    if (otp_refused === 1'b1) n_ref <= n_ref + 1;
    if (dq_oe === 1'b1) n_oe <= n_oe + 1;
    if (cycles == 8000) begin
      num_errors = num_errors + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic cmd(input logic [7:0] c);
    i_flash_host_model.write_cmd(c);
  endtask

  // engine inputs show after one clock
  task automatic stat_is(input logic [7:0] e);
    tick(2);
    chk({8'h00, write_state_status}, {8'h00, e}, "status");
  endtask

  task automatic engine_pulse(input int fail);
    engine_busy = 1'b1;
    program_fail_evt = (fail == 1);
    erase_fail_evt = (fail == 2);
    tick(1);
    program_fail_evt = 1'b0;
    erase_fail_evt = 1'b0;
    tick(2);
    engine_busy = 1'b0;
  endtask

  // region 0 is the parameter group, then the three main blocks next to it
  task automatic otp_case(input int i);
    int k, r, blk, p0, q0;
    logic refd;
    k = $random(seed) & 7;
    top_param = i[0];
    otp_region_en = 4'($random(seed));
    blk = top_param ? NB - 1 - k : k;
    r = top_param ? (blk >= NB - 4 ? 0 : NB - 4 - blk) : (blk < 4 ? 0 : blk - 3);
    refd = (r <= 3) && otp_region_en[r];
    target_block = 7'(blk);
    p0 = n_prog;
    q0 = n_ref;
    cmd(i[1] ? CMD_ERASE_SETUP : CMD_WORD_PROG);
    cmd(i[1] ? CMD_CONFIRM : 8'hA5);
    chk(16'(n_prog - p0), {15'h0000, ~refd}, "op");
    chk(16'(n_ref - q0), {15'h0000, refd}, "refused");
    engine_pulse(0);
    stat_is(refd ? 8'h82 : 8'h80);
    cmd(CMD_CLEAR_STATUS);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(10);
    rstn = 1'b1;
    stat_is(STAT_RESET);
    chk({15'h0000, status_mode}, 16'h0000, "mode");
    cmd(CMD_READ_STATUS);
    oe0 = n_oe;
    i_flash_host_model.read_word(0);
    chk(i_flash_host_model.beats[0], 16'h0080, "read");
    // output enable stands from one clock after the synced read opens until one clock after it closes
    chk(16'(n_oe - oe0), 16'h0005, "oe");
    $display("test status read done");
    cmd(CMD_WORD_PROG);
    cmd(8'h5A);
    chk(16'(n_prog), 16'h0001, "prog");
    stat_is(8'h00);
    supply_low = 1'b1;
    engine_pulse(1);
    supply_low = 1'b0;
    stat_is(8'h98);
    i_flash_host_model.read_word(0);
    chk(i_flash_host_model.beats[0], 16'h0098, "snap");
    supply_low = 1'b1;
    cmd(CMD_CLEAR_STATUS);
    stat_is(8'h80);
    supply_low = 1'b0;
    cmd(CMD_ERASE_SETUP);
    cmd(CMD_LOCK);
    stat_is(8'hB0);
    cmd(CMD_CLEAR_STATUS);
    $display("test program done");
    cmd(CMD_ERASE_SETUP);
    cmd(CMD_CONFIRM);
    engine_busy = 1'b1;
    cmd(CMD_SUSPEND);
    engine_busy = 1'b0;
    engine_erase_suspended = 1'b1;
    stat_is(8'hC0);
    cmd(CMD_LOCK_SETUP);
    cmd(CMD_READ_ARRAY);
    stat_is(8'hF0);
    cmd(CMD_CONFIRM);
    stat_is(8'h30);
    engine_erase_suspended = 1'b0;
    engine_pulse(2);
    stat_is(8'hB0);
    chk(16'(n_oth), 16'h0002, "susp");
    cmd(CMD_CLEAR_STATUS);
    engine_program_suspended = 1'b1;
    factory_busy = 1'b1;
    stat_is(8'h85);
    engine_program_suspended = 1'b0;
    factory_busy = 1'b0;
    locked_block_evt = 1'b1;
    tick(1);
    locked_block_evt = 1'b0;
    stat_is(8'h82);
    cmd(CMD_CLEAR_STATUS);
    $display("test suspend done");
    sync_mode = 1'b1;
    cmd(CMD_READ_STATUS);
    i_flash_host_model.read_word(4);
    foreach (i_flash_host_model.beats[k]) chk(i_flash_host_model.beats[k], 16'h0080, "beat");
    chk({15'h0000, i_flash_host_model.done_seen}, 16'h0001, "done");
    sync_mode = 1'b0;
    array_data = 16'($random(seed));
    cmd(CMD_READ_ARRAY);
    chk({15'h0000, status_mode}, 16'h0000, "mode");
    i_flash_host_model.read_word(0);
    chk(i_flash_host_model.beats[0], array_data, "array");
    $display("test burst done");
    for (int i = 0; i < 16; i++) otp_case(i);
    $display("test otp done");
    give_verdict();
  end
endmodule
